/* rtl/swcc_top.sv */
// sleep/wake sequencer and chip configuration registers
`timescale 1ns/1ps
`default_nettype none

module swcc_top (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic FUSE_CUSTOM,
    input wire logic [31:0] FUSE_CONTROL,
    input wire logic [31:0] FUSE_PIN_SELECT,
    input wire logic CORE_WAIT_DONE,
    input wire logic FAST_INTERRUPT_OUT_N,
    input wire logic STANDBY_N,
    input wire logic PLL_UNLOCK,
    input wire logic PLL_RAW_LOCK,
    input wire logic DEBUG_UNIT_RESET_REQUEST,
    input wire logic WATCHDOG_TIMEOUT,
    input wire logic [29:0] GPIO_IN,
    input wire logic [2:0] AUDIO_PIN_RX,
    input wire logic [2:0] AUDIO_CORE_TX,
    output logic [2:0] AUDIO_PIN_TX,
    output logic AUDIO_PORT_ENABLE,
    output logic CORE_CLOCK_EN,
    output logic SYSTEM_BUS_CLOCK_EN,
    output logic WARM_RESET,
    output logic CLOCK_SOURCE_OVERRIDE,
    output logic SLEEPING,
    output logic [1:0] TIMER1_TRIGGER_SELECT,
    output logic [1:0] TIMER2_TRIGGER_SELECT,
    output logic [1:0] TIMER3_TRIGGER_SELECT,
    output logic [1:0] PORT2_FUNCTION_SELECT,
    output logic CORE_PIN_INT1,
    output logic CORE_PIN_INT2,
    output logic [31:0] PIN_FUNCTION_SELECT
);

logic [31:0] store_reg [swcc_pkg::NREG];
logic [31:0] status_reg;
logic [31:0] wake_reg;
logic fuse_pending_reg;
logic [31:0] prdata_reg;
logic pready_reg;
logic pslverr_reg;
logic hit;
logic [4:0] hit_idx;
logic [31:0] rd_value;
logic setup;
logic wr;
logic sleep_cmd;
logic force_exit_cmd;
swcc_pkg::swcc_state_t state_reg;
swcc_pkg::swcc_state_t state_next;
logic core_en_reg;
logic bus_en_reg;
logic [1:0] bypass_reg;
logic warm_reg;
logic [2:0] src_prev_reg;
logic [2:0] src_event;
logic pll_warm;
logic wake_warm;
logic sb_meta_reg;
logic sb_sync_reg;
logic [29:0] gpio_meta_reg;
logic [29:0] gpio_sync_reg;
logic [2:0] rx_meta_reg;
logic [2:0] rx_sync_reg;
logic [2:0] pin_tx_reg;
logic port_en_reg;
logic int1_reg;
logic int2_reg;
logic gated;
logic wake_hit;
logic sleeping_reg;

// bus: no wait state, read data captured in the setup phase
assign setup = PSEL & ~PENABLE;
assign wr = PSEL & PENABLE & PWRITE & pready_reg & hit;

always_comb begin
    hit = 1'b0;
    hit_idx = 5'h0;
    for (int i = 0; i < swcc_pkg::NREG; i++) begin
        if (PADDR == swcc_pkg::REG_OFFSET[i]) begin
            hit = 1'b1;
            hit_idx = 5'(i);
        end
    end
end

always_comb begin
    if (!hit) begin
        rd_value = 32'h0;
    end else if (hit_idx == 5'(swcc_pkg::IDX_STAT)) begin
        rd_value = status_reg;
    end else if (hit_idx == 5'(swcc_pkg::IDX_WAKE)) begin
        rd_value = wake_reg & swcc_pkg::WAKE_WMASK;
        rd_value[swcc_pkg::W_ASLEEP] = (state_reg == swcc_pkg::SWCC_SLEEP);
        rd_value[swcc_pkg::W_BYPACT] = (bypass_reg != swcc_pkg::BYP_NONE);
    end else begin
        rd_value = store_reg[hit_idx];
    end
end

always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
        pready_reg <= 1'b0;
        prdata_reg <= 32'h0;
        pslverr_reg <= 1'b0;
    end else begin
        pready_reg <= setup;
        // error stands only in the access cycle, together with ready
        pslverr_reg <= setup & ~hit;
        if (setup) begin
            prdata_reg <= PWRITE ? 32'h0 : rd_value;
        end
    end
end

assign PRDATA = prdata_reg;
assign PREADY = pready_reg;
assign PSLVERR = pslverr_reg;

// strap-like fuse values are taken one cycle after reset release
always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
        fuse_pending_reg <= 1'b1;
    end else begin
        fuse_pending_reg <= 1'b0;
    end
end

// plain storage; status and wake-up have their own logic below
for (genvar g = 0; g < swcc_pkg::NREG; g++) begin : g_store
    if (g == swcc_pkg::IDX_STAT || g == swcc_pkg::IDX_WAKE) begin : g_spec
        assign store_reg[g] = 32'h0;
    end else begin : g_plain
        always_ff @(posedge CLOCK) begin
            if (!RST_N) begin
                store_reg[g] <= swcc_pkg::REG_RESET[g];
            end else if (fuse_pending_reg && FUSE_CUSTOM &&
                         g == swcc_pkg::IDX_CTRL) begin
                store_reg[g] <= FUSE_CONTROL & swcc_pkg::CTRL_WMASK;
            end else if (fuse_pending_reg && FUSE_CUSTOM &&
                         g == swcc_pkg::IDX_PINSEL) begin
                store_reg[g] <= FUSE_PIN_SELECT;
            end else if (wr && hit_idx == 5'(g)) begin
                if (g == swcc_pkg::IDX_CTRL) begin
                    store_reg[g] <= PWDATA & swcc_pkg::CTRL_WMASK;
                end else begin
                    store_reg[g] <= PWDATA;
                end
            end
        end
    end
end

// wake-up control: request and force-exit are write-one strobes
assign sleep_cmd = wr && hit_idx == 5'(swcc_pkg::IDX_WAKE)
                   && PWDATA[swcc_pkg::W_SLEEP];
assign force_exit_cmd = wr && hit_idx == 5'(swcc_pkg::IDX_WAKE)
                        && PWDATA[swcc_pkg::W_FORCEX];

always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
        wake_reg <= swcc_pkg::REG_RESET[swcc_pkg::IDX_WAKE];
    end else if (wr && hit_idx == 5'(swcc_pkg::IDX_WAKE)) begin
        wake_reg <= PWDATA & swcc_pkg::WAKE_WMASK;
    end
end

// warm reset sources act on their rising edge only
assign src_event = {PLL_UNLOCK, DEBUG_UNIT_RESET_REQUEST, WATCHDOG_TIMEOUT}
                   & ~src_prev_reg;
assign pll_warm = src_event[2]
                  & ~store_reg[swcc_pkg::IDX_CTRL][swcc_pkg::C_PLL_UNLOCK_RESET_MASK];
assign wake_warm = (state_reg == swcc_pkg::SWCC_WAKE_RST)
                   & wake_reg[swcc_pkg::W_RSTENA];

always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
        src_prev_reg <= 3'h0;
        warm_reg <= 1'b0;
    end else begin
        src_prev_reg <= {PLL_UNLOCK, DEBUG_UNIT_RESET_REQUEST,
                         WATCHDOG_TIMEOUT};
        warm_reg <= pll_warm
            | (src_event[1] & ~store_reg[swcc_pkg::IDX_CTRL][swcc_pkg::C_DBG_MSK])
            | (src_event[0] & ~store_reg[swcc_pkg::IDX_CTRL][swcc_pkg::C_WATCHDOG_RESET_MASK])
            | wake_warm;
    end
end

// sticky flags: a new event in the clearing cycle keeps the flag set
always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
        status_reg <= swcc_pkg::REG_RESET[swcc_pkg::IDX_STAT];
    end else begin
        if (wr && hit_idx == 5'(swcc_pkg::IDX_STAT)) begin
            for (int b = swcc_pkg::S_WAKE; b <= swcc_pkg::S_PLL; b++) begin
                if (PWDATA[b]) begin
                    status_reg[b] <= 1'b0;
                end
            end
        end
        if (PLL_UNLOCK) begin
            status_reg[swcc_pkg::S_PLL] <= 1'b1;
        end
        if (DEBUG_UNIT_RESET_REQUEST) begin
            status_reg[swcc_pkg::S_DBG] <= 1'b1;
        end
        if (WATCHDOG_TIMEOUT) begin
            status_reg[swcc_pkg::S_WDT] <= 1'b1;
        end
        if (pll_warm) begin
            status_reg[swcc_pkg::S_OVR] <= 1'b1;
        end
        if (wake_warm) begin
            status_reg[swcc_pkg::S_WAKE] <= 1'b1;
        end
        status_reg[swcc_pkg::S_UNLOCK] <= PLL_UNLOCK;
        status_reg[swcc_pkg::S_RAWLOCK] <= PLL_RAW_LOCK;
    end
end

// pins from outside the clock domain
always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
        sb_meta_reg <= 1'b1;
        sb_sync_reg <= 1'b1;
        gpio_meta_reg <= 30'h0;
        gpio_sync_reg <= 30'h0;
        rx_meta_reg <= 3'h0;
        rx_sync_reg <= 3'h0;
    end else begin
        sb_meta_reg <= STANDBY_N;
        sb_sync_reg <= sb_meta_reg;
        gpio_meta_reg <= GPIO_IN;
        gpio_sync_reg <= gpio_meta_reg;
        rx_meta_reg <= AUDIO_PIN_RX;
        rx_sync_reg <= rx_meta_reg;
    end
end

// once any clock is gated the interrupt unit is frozen, so standby alone
assign gated = wake_reg[swcc_pkg::W_CGATE] | wake_reg[swcc_pkg::W_BGATE];
assign wake_hit = gated ? ~sb_sync_reg : ~FAST_INTERRUPT_OUT_N;

// sleep request never touches the core; it idles on its own instruction
always_comb begin
    state_next = state_reg;
    case (state_reg)
        swcc_pkg::SWCC_IDLE: begin
            if (sleep_cmd) begin
                // the wait enable may arrive in the very write that requests sleep
                state_next = PWDATA[swcc_pkg::W_WAIT]
                             ? swcc_pkg::SWCC_WAIT_CORE : swcc_pkg::SWCC_GATE;
            end
        end
        swcc_pkg::SWCC_WAIT_CORE: begin
            if (CORE_WAIT_DONE) begin
                state_next = swcc_pkg::SWCC_GATE;
            end
        end
        swcc_pkg::SWCC_GATE: state_next = swcc_pkg::SWCC_BYPASS;
        swcc_pkg::SWCC_BYPASS: state_next = swcc_pkg::SWCC_SLEEP;
        swcc_pkg::SWCC_SLEEP: begin
            if (wake_hit) begin
                state_next = swcc_pkg::SWCC_WAKE_CLK;
            end
        end
        swcc_pkg::SWCC_WAKE_CLK: state_next = swcc_pkg::SWCC_WAKE_RST;
        swcc_pkg::SWCC_WAKE_RST: state_next = swcc_pkg::SWCC_WAKE_BYP;
        swcc_pkg::SWCC_WAKE_BYP: state_next = swcc_pkg::SWCC_IDLE;
        default: state_next = swcc_pkg::SWCC_IDLE;
    endcase
end

always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
        state_reg <= swcc_pkg::SWCC_IDLE;
        sleeping_reg <= 1'b0;
    end else begin
        state_reg <= state_next;
        sleeping_reg <= (state_next == swcc_pkg::SWCC_SLEEP);
    end
end

always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
        core_en_reg <= 1'b1;
        bus_en_reg <= 1'b1;
    end else if (state_reg == swcc_pkg::SWCC_GATE) begin
        core_en_reg <= ~wake_reg[swcc_pkg::W_CGATE];
        bus_en_reg <= ~wake_reg[swcc_pkg::W_BGATE];
    end else if (state_reg == swcc_pkg::SWCC_WAKE_CLK) begin
        core_en_reg <= 1'b1;
        bus_en_reg <= 1'b1;
    end
end

// bypass applied last on entry, left last on wake
always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
        bypass_reg <= swcc_pkg::BYP_NONE;
    end else if (state_reg == swcc_pkg::SWCC_BYPASS) begin
        bypass_reg <= wake_reg[swcc_pkg::W_BYP +: 2];
    end else if (force_exit_cmd) begin
        bypass_reg <= swcc_pkg::BYP_NONE;
    end else if (state_reg == swcc_pkg::SWCC_WAKE_BYP
                 && wake_reg[swcc_pkg::W_AUTOX]) begin
        bypass_reg <= swcc_pkg::BYP_NONE;
    end
end

// loop-through adds the synchroniser latency; fine for slow audio bits
always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
        pin_tx_reg <= 3'h0;
        port_en_reg <= 1'b1;
    end else begin
        port_en_reg <= (bypass_reg == swcc_pkg::BYP_NONE);
        pin_tx_reg <= AUDIO_CORE_TX;
        case (bypass_reg)
            swcc_pkg::BYP_01: begin
                pin_tx_reg[0] <= rx_sync_reg[1];
                pin_tx_reg[1] <= rx_sync_reg[0];
            end
            swcc_pkg::BYP_02: begin
                pin_tx_reg[0] <= rx_sync_reg[2];
                pin_tx_reg[2] <= rx_sync_reg[0];
            end
            swcc_pkg::BYP_12: begin
                pin_tx_reg[1] <= rx_sync_reg[2];
                pin_tx_reg[2] <= rx_sync_reg[1];
            end
            default: begin
            end
        endcase
    end
end

function automatic logic pick_pin(input logic [4:0] sel,
                                  input logic [29:0] pins);
    logic r;
    r = 1'b0;
    if (sel == swcc_pkg::SEL_ONE) begin
        r = 1'b1;
    end else if (sel < swcc_pkg::SEL_ZERO) begin
        r = pins[sel];
    end
    return r;
endfunction

always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
        int1_reg <= 1'b0;
        int2_reg <= 1'b0;
    end else begin
        int1_reg <= pick_pin(store_reg[swcc_pkg::IDX_CTRL][swcc_pkg::C_INT1 +: 5],
                             gpio_sync_reg);
        int2_reg <= pick_pin(store_reg[swcc_pkg::IDX_CTRL][swcc_pkg::C_INT2 +: 5],
                             gpio_sync_reg);
    end
end

assign AUDIO_PIN_TX = pin_tx_reg;
assign AUDIO_PORT_ENABLE = port_en_reg;
assign CORE_CLOCK_EN = core_en_reg;
assign SYSTEM_BUS_CLOCK_EN = bus_en_reg;
assign WARM_RESET = warm_reg;
assign CLOCK_SOURCE_OVERRIDE = status_reg[swcc_pkg::S_OVR];
assign SLEEPING = sleeping_reg;
assign TIMER1_TRIGGER_SELECT = store_reg[swcc_pkg::IDX_CTRL][swcc_pkg::C_TMR1 +: 2];
assign TIMER2_TRIGGER_SELECT = store_reg[swcc_pkg::IDX_CTRL][swcc_pkg::C_TMR2 +: 2];
assign TIMER3_TRIGGER_SELECT = store_reg[swcc_pkg::IDX_CTRL][swcc_pkg::C_TMR3 +: 2];
assign PORT2_FUNCTION_SELECT = store_reg[swcc_pkg::IDX_CTRL][swcc_pkg::C_PORT2 +: 2];
assign CORE_PIN_INT1 = int1_reg;
assign CORE_PIN_INT2 = int2_reg;
assign PIN_FUNCTION_SELECT = store_reg[swcc_pkg::IDX_PINSEL];

endmodule

`default_nettype wire

/* shared/swcc_pkg.sv */
// constants for the sleep/wake chip configuration block
package swcc_pkg;

localparam int NREG = 27;
localparam int AW = 8;

localparam logic [AW-1:0] REG_OFFSET [NREG] = '{
    8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
    8'h24, 8'h28, 8'h30, 8'h44, 8'h48, 8'h4c, 8'h50,
    8'h54, 8'h58, 8'h5c, 8'h60, 8'h64, 8'h68, 8'h6c,
    8'h70, 8'h74, 8'h78, 8'h7c, 8'h84, 8'h88};

localparam logic [31:0] REG_RESET [NREG] = '{
    32'h001e1e00, 32'h80000000, 32'h00000000, 32'h00000011,
    32'h03de0000, 32'h00000000, 32'h33120e00, 32'h02ba187f,
    32'h00ba087f, 32'h00010000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h77770000, 32'hff7fff7f, 32'h77777777,
    32'h77777700, 32'h7d777777, 32'h77777770, 32'h07070707,
    32'h0f070700, 32'h07070707, 32'h0f070700};

localparam int IDX_CTRL = 0;
localparam int IDX_STAT = 1;
localparam int IDX_PINSEL = 2;
localparam int IDX_WAKE = 9;

// general control fields
localparam logic [31:0] CTRL_WMASK = 32'hefdf1fc0;
localparam int C_PLL_UNLOCK_RESET_MASK = 31;
localparam int C_DBG_MSK = 30;
localparam int C_WATCHDOG_RESET_MASK = 29;
localparam int C_TMR3 = 26;
localparam int C_TMR2 = 24;
localparam int C_TMR1 = 22;
localparam int C_INT2 = 16;
localparam int C_INT1 = 8;
localparam int C_PORT2 = 6;

// general status fields
localparam int S_PLL = 31;
localparam int S_DBG = 30;
localparam int S_WDT = 29;
localparam int S_OVR = 28;
localparam int S_WAKE = 27;
localparam int S_UNLOCK = 1;
localparam int S_RAWLOCK = 0;

// wake-up control fields
localparam logic [31:0] WAKE_WMASK = 32'h0001013e;
localparam int W_SLEEP = 0;
localparam int W_WAIT = 1;
localparam int W_CGATE = 2;
localparam int W_BGATE = 3;
localparam int W_BYP = 4;
localparam int W_AUTOX = 8;
localparam int W_FORCEX = 9;
localparam int W_RSTENA = 16;
localparam int W_ASLEEP = 24;
localparam int W_BYPACT = 25;

localparam int NGPIO = 30;
localparam logic [4:0] SEL_ZERO = 5'h1e;
localparam logic [4:0] SEL_ONE = 5'h1f;
localparam logic [1:0] BYP_NONE = 2'h0;
localparam logic [1:0] BYP_01 = 2'h1;
localparam logic [1:0] BYP_02 = 2'h2;
localparam logic [1:0] BYP_12 = 2'h3;

typedef enum logic [2:0] {
    SWCC_IDLE, SWCC_WAIT_CORE, SWCC_GATE, SWCC_BYPASS,
    SWCC_SLEEP, SWCC_WAKE_CLK, SWCC_WAKE_RST, SWCC_WAKE_BYP
} swcc_state_t;

endpackage

/* verif/swcc_checker.sv */
// port-level assertions for the sleep/wake configuration block
`timescale 1ns/1ps
`default_nettype none
module swcc_checker (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic STANDBY_N,
    input wire logic [2:0] AUDIO_CORE_TX,
    input wire logic [2:0] AUDIO_PIN_TX,
    input wire logic AUDIO_PORT_ENABLE,
    input wire logic CORE_CLOCK_EN,
    input wire logic SYSTEM_BUS_CLOCK_EN,
    input wire logic WARM_RESET,
    input wire logic CLOCK_SOURCE_OVERRIDE,
    input wire logic SLEEPING,
    input wire logic [1:0] TIMER1_TRIGGER_SELECT,
    input wire logic [1:0] TIMER3_TRIGGER_SELECT,
    input wire logic [1:0] PORT2_FUNCTION_SELECT,
    input wire logic [31:0] PIN_FUNCTION_SELECT
);
default clocking cb @(posedge CLOCK); endclocking
default disable iff (!RST_N);
logic [31:0] wd_reg;
logic wr;
assign wr = PSEL && PENABLE && PWRITE && PREADY && !PSLVERR;
// last accepted write word; apb spacing keeps it valid for two cycles
always_ff @(posedge CLOCK) begin
    if (wr) begin
        wd_reg <= PWDATA;
    end
end
property p_ready; PSEL && !PENABLE |=> PREADY ##1 !PREADY; endproperty
property p_err; PSLVERR |-> PREADY && PENABLE; endproperty
property p_pulse; WARM_RESET |=> !WARM_RESET; endproperty
property p_wake; $fell(SLEEPING) |-> ##[0:2] (CORE_CLOCK_EN && SYSTEM_BUS_CLOCK_EN); endproperty
// four standby samples cover the pin synchroniser depth
property p_gated;
    (!CORE_CLOCK_EN || !SYSTEM_BUS_CLOCK_EN) && SLEEPING && STANDBY_N && $past(STANDBY_N)
        && $past(STANDBY_N, 2) && $past(STANDBY_N, 3) |=> SLEEPING;
endproperty
property p_loop;
    $past(RST_N) && AUDIO_PORT_ENABLE && $past(AUDIO_PORT_ENABLE) |-> AUDIO_PIN_TX == $past(AUDIO_CORE_TX);
endproperty
property p_ctrl;
    wr && PADDR == 8'h00 |-> ##[1:2] (TIMER1_TRIGGER_SELECT == wd_reg[23:22]
        && TIMER3_TRIGGER_SELECT == wd_reg[27:26] && PORT2_FUNCTION_SELECT == wd_reg[7:6]);
endproperty
property p_pinsel; wr && PADDR == 8'h0c |-> ##[1:2] PIN_FUNCTION_SELECT == wd_reg; endproperty
property p_ovr; $rose(CLOCK_SOURCE_OVERRIDE) |-> WARM_RESET || $past(WARM_RESET) || $past(WARM_RESET, 2); endproperty
property p_gate; $fell(SYSTEM_BUS_CLOCK_EN) |-> ##[0:3] SLEEPING; endproperty
a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
a_err: assert property (p_err) else $error("slave error outside access");
a_pulse: assert property (p_pulse) else $error("warm reset longer than one cycle");
a_wake: assert property (p_wake) else $error("clocks not back after wake");
a_gated: assert property (p_gated) else $error("woke without standby while gated");
a_loop: assert property (p_loop) else $error("audio tx not from core");
a_ctrl: assert property (p_ctrl) else $error("control fields not applied");
a_pinsel: assert property (p_pinsel) else $error("pin select not applied");
a_ovr: assert property (p_ovr) else $error("override without warm reset");
a_gate: assert property (p_gate) else $error("bus clock gated outside sleep entry");
c_sleep: cover property ($rose(SLEEPING));
c_warm: cover property (WARM_RESET);
c_bypass: cover property ($fell(AUDIO_PORT_ENABLE));
endmodule
`default_nettype wire

/* verif/swcc_partner.sv */
// core and interrupt unit model facing the sleep sequencer
`timescale 1ns/1ps
`default_nettype none
module swcc_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wait_go,
    input wire logic [3:0] wait_lat,
    input wire logic irq_go,
    output logic wait_done,
    output logic fast_interrupt_out_n
);
logic [3:0] cnt_reg;
// core only idles once its own wait instruction has run out
always_ff @(posedge clk) begin
    if (!rst_n || !wait_go) begin
        cnt_reg <= 4'h0;
        wait_done <= 1'b0;
    end else if (cnt_reg == wait_lat) begin
        wait_done <= 1'b1;
    end else begin
        cnt_reg <= cnt_reg + 4'h1;
    end
end
always_ff @(posedge clk) begin
    fast_interrupt_out_n <= !(rst_n && irq_go);
end
endmodule
`default_nettype wire

/* verif/swcc_tb_top.sv */
// self-checking testbench for the sleep/wake configuration block
`timescale 1ns/1ps
`default_nettype none
module swcc_tb_top;
logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, prdata, pfs;
logic pready, pslverr, standby_n = 1'b1, wait_go = 1'b0, irq_go = 1'b0, lock = 1'b0, fuse_custom = 1'b0;
logic [31:0] fuse_ctrl = 32'h12345678, fuse_pin = 32'h0f0f1234;
logic [3:0] wait_lat = 4'h2;
logic [2:0] src = 3'h0, rx = 3'h0, ctx = 3'h5, ptx;
logic [29:0] gpio = 30'h2aaaaaaa;
logic wdone, fast_interrupt_out_n, ape, cce, sbe, warm, cso, slp, i1, i2;
logic [1:0] t1, t2, t3, p2;
int errors = 0, checks = 0;
swcc_top u_swcc_top (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FUSE_CUSTOM(fuse_custom), .FUSE_CONTROL(fuse_ctrl), .FUSE_PIN_SELECT(fuse_pin), .CORE_WAIT_DONE(wdone),
    .FAST_INTERRUPT_OUT_N(fast_interrupt_out_n), .STANDBY_N(standby_n), .PLL_UNLOCK(src[2]), .PLL_RAW_LOCK(lock),
    .DEBUG_UNIT_RESET_REQUEST(src[1]), .WATCHDOG_TIMEOUT(src[0]), .GPIO_IN(gpio), .AUDIO_PIN_RX(rx),
    .AUDIO_CORE_TX(ctx), .AUDIO_PIN_TX(ptx), .AUDIO_PORT_ENABLE(ape), .CORE_CLOCK_EN(cce),
    .SYSTEM_BUS_CLOCK_EN(sbe), .WARM_RESET(warm), .CLOCK_SOURCE_OVERRIDE(cso), .SLEEPING(slp),
    .TIMER1_TRIGGER_SELECT(t1), .TIMER2_TRIGGER_SELECT(t2), .TIMER3_TRIGGER_SELECT(t3),
    .PORT2_FUNCTION_SELECT(p2), .CORE_PIN_INT1(i1), .CORE_PIN_INT2(i2), .PIN_FUNCTION_SELECT(pfs));
swcc_partner u_swcc_partner (.clk(clk), .rst_n(rst_n), .wait_go(wait_go), .wait_lat(wait_lat),
    .irq_go(irq_go), .wait_done(wdone), .fast_interrupt_out_n(fast_interrupt_out_n));
always #20 clk = ~clk;
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
        errors++;
        $display("Error %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                   output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
        @(posedge clk);
        n++;
    end while (pready !== 1'b1 && n < 4);
    chk("pready", 32'h1, 32'(pready));
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next setup never lands in the release time step
    @(posedge clk);
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk("read", x, q);
endtask
task automatic wait_slp(input logic v, input int n);
    int k;
    k = 0;
    while (slp !== v && k < n) begin
        @(posedge clk);
        k++;
    end
    chk("sleeping", 32'(v), 32'(slp));
endtask
task automatic count_warm(input int n, inout int c);
    repeat (n) begin
        @(posedge clk);
        if (warm === 1'b1) c++;
    end
endtask
task automatic t_regs;
    logic [31:0] q;
    logic e;
    for (int i = 0; i < swcc_pkg::NREG; i++) begin
        rd(swcc_pkg::REG_OFFSET[i], swcc_pkg::REG_RESET[i]);
    end
    for (int i = swcc_pkg::IDX_PINSEL; i < swcc_pkg::NREG; i++) begin
        if (i != swcc_pkg::IDX_WAKE) begin
            wr(swcc_pkg::REG_OFFSET[i], 32'h5a5a5a5a ^ i);
            rd(swcc_pkg::REG_OFFSET[i], 32'h5a5a5a5a ^ i);
        end
    end
    chk("pin_select", 32'h5a5a5a58, pfs);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk("unmapped_err", 32'h1, 32'(e));
    chk("unmapped_data", 32'h0, q);
endtask
task automatic t_ctrl;
    logic [31:0] d;
    logic [4:0] s1, s2;
    wr(8'h00, 32'hffffffff);
    rd(8'h00, swcc_pkg::CTRL_WMASK);
    for (int k = 0; k < 4; k++) begin
        s1 = 5'(k * 7);
        s2 = (k < 2) ? swcc_pkg::SEL_ZERO + 5'(k) : 5'(k * 13 - 13);
        d = {3'h7, 1'b0, 2'(k), 2'(k + 1), 2'(k + 2), 1'b0, s2, 3'h0, s1, 2'(3 - k), 6'h0};
        wr(8'h00, d);
        repeat (3) @(posedge clk);
        chk("timers_port2", 32'({2'(k), 2'(k + 1), 2'(k + 2), 2'(3 - k)}), 32'({t3, t2, t1, p2}));
        chk("core_int1", 32'(gpio[s1]), 32'(i1));
        chk("core_int2", 32'(k == 1 || (k > 1 && gpio[s2])), 32'(i2));
    end
    wr(8'h00, 32'h001e1e00);
endtask
task automatic t_warm;
    int c;
    logic m;
    logic [31:0] x;
    lock <= 1'b1;
    wr(8'h04, 32'hf8000000);
    for (int i = 0; i < 3; i++) begin
        for (int j = 0; j < 2; j++) begin
            m = 1'(j);
            wr(8'h00, 32'h001e1e00 | (32'(m) << (31 - i)));
            src <= 3'h4 >> i;
            c = 0;
            count_warm(3, c);
            src <= 3'h0;
            count_warm(5, c);
            chk("warm_count", 32'(!m), 32'(c));
            x = (32'h80000000 >> i) | 32'h1 | ((i == 0 && !m) ? 32'h10000000 : 32'h0);
            rd(8'h04, x);
            chk("override", 32'(i == 0 && !m), 32'(cso));
            wr(8'h04, 32'hf8000000);
            rd(8'h04, 32'h1);
        end
    end
    wr(8'h00, 32'h001e1e00);
endtask
task automatic t_bypass;
    int c;
    rx <= 3'h2;
    wr(8'h30, 32'h00000011);
    wait_slp(1'b1, 10);
    chk("clocks", 32'h3, 32'({cce, sbe}));
    repeat (4) @(posedge clk);
    chk("port_en", 32'h0, 32'(ape));
    chk("loop", 32'h1, 32'(ptx & 3'h3));
    rd(8'h30, 32'h03000010);
    irq_go <= 1'b1;
    wait_slp(1'b0, 10);
    c = 0;
    count_warm(6, c);
    irq_go <= 1'b0;
    chk("warm_count", 32'h0, 32'(c));
    chk("port_en", 32'h0, 32'(ape));
    rd(8'h30, 32'h02000010);
    ctx <= 3'h2;
    wr(8'h30, 32'h00000210);
    repeat (3) @(posedge clk);
    chk("port_en", 32'h1, 32'(ape));
    chk("tx", 32'h2, 32'(ptx));
    wr(8'h30, 32'h00000031);
    wait_slp(1'b1, 10);
    repeat (2) @(posedge clk);
    chk("loop", 32'h4, 32'(ptx));
    irq_go <= 1'b1;
    wait_slp(1'b0, 10);
    irq_go <= 1'b0;
    wr(8'h30, 32'h00000200);
    repeat (3) @(posedge clk);
    chk("port_en", 32'h1, 32'(ape));
endtask
task automatic t_deep;
    int c;
    rx <= 3'h1;
    wait_lat <= 4'h5;
    wr(8'h30, 32'h0001012f);
    repeat (8) @(posedge clk);
    chk("stall_clocks", 32'h3, 32'({cce, sbe}));
    chk("stall_sleep", 32'h0, 32'(slp));
    wait_go <= 1'b1;
    wait_slp(1'b1, 20);
    chk("clocks", 32'h0, 32'({cce, sbe}));
    irq_go <= 1'b1;
    repeat (10) @(posedge clk);
    chk("loop", 32'h4, 32'(ptx & 3'h5));
    chk("still_asleep", 32'h1, 32'(slp));
    standby_n <= 1'b0;
    wait_slp(1'b0, 10);
    c = 0;
    count_warm(8, c);
    chk("warm_count", 32'h1, 32'(c));
    chk("clocks", 32'h3, 32'({cce, sbe}));
    chk("port_en", 32'h1, 32'(ape));
    rd(8'h04, 32'h08000001);
    standby_n <= 1'b1;
    irq_go <= 1'b0;
    wait_go <= 1'b0;
    wr(8'h04, 32'h08000000);
endtask
// mid-run reset on a custom part: fuse images replace the control and pin tables
task automatic t_fuse;
    fuse_custom <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h00, 32'h02141640);
    rd(8'h0c, 32'h0f0f1234);
    rd(8'h04, 32'h80000001);
    rd(8'h30, 32'h00010000);
    chk("pin_select", 32'h0f0f1234, pfs);
endtask
task automatic stop_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask
initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs;
    t_ctrl;
    t_warm;
    t_bypass;
    t_deep;
    t_fuse;
    stop_test;
end
// whole run is a few hundred cycles; this is ten thousand cycles
initial begin
    #400000;
    errors++;
    stop_test;
end
endmodule
bind swcc_top swcc_checker u_swcc_checker (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .STANDBY_N(STANDBY_N), .AUDIO_CORE_TX(AUDIO_CORE_TX), .AUDIO_PIN_TX(AUDIO_PIN_TX),
    .AUDIO_PORT_ENABLE(AUDIO_PORT_ENABLE), .CORE_CLOCK_EN(CORE_CLOCK_EN),
    .SYSTEM_BUS_CLOCK_EN(SYSTEM_BUS_CLOCK_EN), .WARM_RESET(WARM_RESET),
    .CLOCK_SOURCE_OVERRIDE(CLOCK_SOURCE_OVERRIDE), .SLEEPING(SLEEPING),
    .TIMER1_TRIGGER_SELECT(TIMER1_TRIGGER_SELECT), .TIMER3_TRIGGER_SELECT(TIMER3_TRIGGER_SELECT),
    .PORT2_FUNCTION_SELECT(PORT2_FUNCTION_SELECT), .PIN_FUNCTION_SELECT(PIN_FUNCTION_SELECT));
`default_nettype wire
